//--- logic/icr_pkg.sv
package icr_pkg;

    // -------------------------------------------------------------------
    // Array geometry and bus widths
    // -------------------------------------------------------------------
    localparam int unsigned NUM_COLS    = 1280;
    localparam int unsigned NUM_STAGES  = NUM_COLS / 2;
    localparam int unsigned COL_W       = 11;
    localparam int unsigned STAGE_W     = 10;
    localparam int unsigned PIX_W       = 10;
    localparam int unsigned KNEE_W      = 3;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CAL_TIME_NS   = 3500;
    localparam int unsigned CAL_CYCLES    =
        (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAL_CNT_W     = 8;

    // -------------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_START  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_LEN    = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;

    // Control register field positions.
    localparam int unsigned CTRL_SUB_BIT   = 0;
    localparam int unsigned CTRL_SWAPA_BIT = 1;
    localparam int unsigned CTRL_SWAPB_BIT = 2;
    localparam int unsigned CTRL_EXTV_BIT  = 3;
    localparam int unsigned CTRL_KNEE_LSB  = 8;

    // Reset values.
    localparam logic [COL_W-1:0]   START_RST = 11'h000;
    localparam logic [STAGE_W-1:0] LEN_RST   = 10'h27f;
    localparam logic [KNEE_W-1:0]  KNEE_RST  = 3'h0;

    // Readout sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CAL   = 2'b01,
        ST_SYNC  = 2'b10,
        ST_SHIFT = 2'b11
    } icr_state_t;

    // Column readout configuration carried as one group.
    typedef struct packed {
        logic               sub_en;
        logic               swap_a;
        logic               swap_b;
        logic               ext_knee_sel;
        logic [KNEE_W-1:0]  knee_level_bits;
        logic [COL_W-1:0]   col_start;
        logic [STAGE_W-1:0] pair_count;
    } icr_cfg_t;

    // Column pair presented to the two column buses.
    typedef struct packed {
        logic [COL_W-1:0] even_col;
        logic [COL_W-1:0] odd_col;
    } icr_cols_t;

endpackage

//--- logic/icr_readout.sv
// Notes on behaviour
// - Sequencer makes pixel reset, sample and hold from start and stop pins.
// - After readout start, run a 3.5 us double-sampling calibration.
// - Pixels go out only after row blanking has ended.
// - Exactly one pixel leaves per system clock.
// - Each shift stage selects two columns; stages advance every other clock.
// - Even columns on bus A, odd on bus B, interleaved into one stream. Sub-sampling with one swap puts odd columns on A or even on B.
// - At blanking end, under column sync, load a single one at start.
// - Releasing column sync starts shifting onward from the start stage.
// - Sub-sampling off: pointer advances one stage per shift.
// - Sub-sampling on: pointer advances two stages, pattern XXOOXXOO.
// - Sub-sampling with first swap gives pattern XOXOXOXO.
// - Sub-sampling with second swap gives pattern OXOXOXOX.
// - Sub-sampling with both swaps gives pattern OOXXOOXX.
// - Knee-level bits set the internal multiple-slope reset level.
// - External-knee select disconnects the internal generator from its pin.
//
// Our own choices: the register offsets and strobed register access.
module icr_readout
    import icr_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               sys_rst_i,
    // Register port.
    input  wire logic [ADDR_W-1:0]  reg_addr_i,
    input  wire logic [DATA_W-1:0]  reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [DATA_W-1:0]  reg_rdata_o,
    // Sequencing pins from the camera controller.
    input  wire logic               int_start_i,
    input  wire logic               int_stop_i,
    input  wire logic               row_start_i,
    input  wire logic               row_clock_i,
    // Shutter controls to the pixel array.
    output logic                    pix_reset_o,
    output logic                    pix_sample_o,
    output logic                    pix_hold_o,
    // Calibration and column addressing.
    output logic                    cal_active_o,
    output logic                    col_sync_o,
    output icr_cols_t               col_sel_o,
    // Column buses and pixel stream.
    input  wire logic [PIX_W-1:0]   bus_a_i,
    input  wire logic [PIX_W-1:0]   bus_b_i,
    output logic      [PIX_W-1:0]   pixel_o,
    output logic                    pixel_valid_o,
    // Multiple-slope reset voltage generator.
    output logic      [KNEE_W-1:0]  knee_level_bits_o,
    output logic                    knee_gen_connect_o
);

    // -------------------------------------------------------------------
    // Column address decoding
    // -------------------------------------------------------------------

    // Maps a stage to the two columns driven onto buses A and B. In
    // sub-sample mode the swap switches reroute columns inside each group
    // of four, which is what produces the four skip patterns.
    function automatic icr_cols_t col_pick(input logic [STAGE_W-1:0] stg,
                                           input icr_cfg_t         c);
        logic [COL_W-1:0] base;
        logic [COL_W-1:0] grp;
        icr_cols_t        r;
        base = {stg, 1'b0};
        grp  = {stg[STAGE_W-1:1], 2'b00};
        r.even_col = base;
        r.odd_col  = base | 11'h001;
        if (c.sub_en) begin
            unique case ({c.swap_b, c.swap_a})
                2'b00: begin
                    r.even_col = grp;
                    r.odd_col  = grp | 11'h001;
                end
                2'b01: begin
                    r.even_col = grp;
                    r.odd_col  = grp | 11'h002;
                end
                2'b10: begin
                    r.even_col = grp | 11'h001;
                    r.odd_col  = grp | 11'h003;
                end
                2'b11: begin
                    r.even_col = grp | 11'h002;
                    r.odd_col  = grp | 11'h003;
                end
            endcase
        end
        return r;
    endfunction

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    icr_cfg_t               cfg_r;
    icr_state_t             state_r;
    icr_state_t             state_nxt;
    logic [CAL_CNT_W-1:0]   cal_cnt_r;
    logic [NUM_STAGES-1:0]  shreg_r;
    logic [STAGE_W-1:0]     stage_r;
    logic [STAGE_W-1:0]     pairs_left_r;
    logic                   phase_r;
    logic                   integrating_r;
    logic [STAGE_W-1:0]     start_stage;
    logic [STAGE_W-1:0]     step;
    logic                   row_go;
    logic                   cal_done;
    logic                   last_pair;

    assign start_stage = cfg_r.col_start[COL_W-1:1];
    assign step        = cfg_r.sub_en ? 10'h002 : 10'h001;
    assign row_go      = row_start_i && row_clock_i;
    assign cal_done    = (cal_cnt_r == CAL_CNT_W'(CAL_CYCLES - 1));
    assign last_pair   = (pairs_left_r == 10'h000);

    // -------------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------------

    // Configuration writes; a row in flight sees CTRL changes immediately, while
    // start and length are only taken at sync, so software should reprogram between rows.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cfg_r.sub_en          <= 1'b0;
            cfg_r.swap_a          <= 1'b0;
            cfg_r.swap_b          <= 1'b0;
            cfg_r.ext_knee_sel    <= 1'b0;
            cfg_r.knee_level_bits <= KNEE_RST;
            cfg_r.col_start       <= START_RST;
            cfg_r.pair_count      <= LEN_RST;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                REG_CTRL: begin
                    cfg_r.sub_en          <= reg_wdata_i[CTRL_SUB_BIT];
                    cfg_r.swap_a          <= reg_wdata_i[CTRL_SWAPA_BIT];
                    cfg_r.swap_b          <= reg_wdata_i[CTRL_SWAPB_BIT];
                    cfg_r.ext_knee_sel    <= reg_wdata_i[CTRL_EXTV_BIT];
                    cfg_r.knee_level_bits <=
                        reg_wdata_i[CTRL_KNEE_LSB +: KNEE_W];
                end
                REG_START: cfg_r.col_start <= {reg_wdata_i[COL_W-1:1], 1'b0};
                REG_LEN:   cfg_r.pair_count <= reg_wdata_i[STAGE_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data stands in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL: reg_rdata_o <= DATA_W'({cfg_r.knee_level_bits,
                    4'h0, cfg_r.ext_knee_sel, cfg_r.swap_b, cfg_r.swap_a,
                    cfg_r.sub_en});
                REG_START:  reg_rdata_o <= DATA_W'(cfg_r.col_start);
                REG_LEN:    reg_rdata_o <= DATA_W'(cfg_r.pair_count);
                REG_STATUS: reg_rdata_o <= DATA_W'({stage_r,
                    integrating_r, 3'h0, state_r});
                default:    reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // -------------------------------------------------------------------
    // Shutter sequencer
    // -------------------------------------------------------------------

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pix_reset_o   <= 1'b0;
            pix_sample_o  <= 1'b0;
            pix_hold_o    <= 1'b0;
            integrating_r <= 1'b0;
        end else begin
            pix_reset_o  <= int_start_i;
            pix_sample_o <= int_stop_i && integrating_r && !int_start_i;
            if (int_start_i) begin
                integrating_r <= 1'b1;
                pix_hold_o    <= 1'b0;
            end else if (int_stop_i && integrating_r) begin
                integrating_r <= 1'b0;
                pix_hold_o    <= 1'b1; // Held charge stays until next start.
            end
        end
    end

    // -------------------------------------------------------------------
    // Row readout sequencer
    // -------------------------------------------------------------------

    // Next state; a new row request during a row is ignored.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  if (row_go) state_nxt = ST_CAL;
            ST_CAL:   if (cal_done) state_nxt = ST_SYNC;
            ST_SYNC:  state_nxt = ST_SHIFT;
            ST_SHIFT: if (phase_r && last_pair) state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || state_r != ST_CAL) begin
            cal_cnt_r <= '0;
        end else begin
            cal_cnt_r <= cal_cnt_r + 8'h01;
        end
    end

    // Calibration strobe and column sync pulse.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cal_active_o <= 1'b0;
            col_sync_o   <= 1'b0;
        end else begin
            cal_active_o <= (state_nxt == ST_CAL);
            col_sync_o   <= (state_nxt == ST_SYNC);
        end
    end

    // -------------------------------------------------------------------
    // Column shift register
    // -------------------------------------------------------------------

    // Two-cycle phase: stages move only when phase wraps, which gives the
    // half-rate enable without a second clock.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || state_r != ST_SHIFT) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    // The one-hot register is the real pointer; stage_r mirrors its index
    // so the column decode avoids a 640-input encoder.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            shreg_r      <= '0;
            stage_r      <= '0;
            pairs_left_r <= '0;
        end else if (state_r == ST_SYNC) begin
            shreg_r      <= NUM_STAGES'(1) << start_stage;
            stage_r      <= start_stage;
            pairs_left_r <= cfg_r.pair_count;
        end else if (state_r == ST_SHIFT && phase_r && !last_pair) begin
            shreg_r      <= shreg_r << step;
            stage_r      <= stage_r + step;
            pairs_left_r <= pairs_left_r - 10'h001;
        end
    end

    // Column select follows the pointer; held for both halves of a stage.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            col_sel_o <= '0;
        end else if (state_nxt == ST_SHIFT) begin
            col_sel_o <= col_pick(state_r == ST_SHIFT ?
                ((phase_r && !last_pair) ? stage_r + step : stage_r) :
                start_stage, cfg_r);
        end
    end

    // -------------------------------------------------------------------
    // Output stage
    // -------------------------------------------------------------------

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pixel_o       <= '0;
            pixel_valid_o <= 1'b0;
        end else if (state_r == ST_SHIFT) begin
            pixel_o       <= phase_r ? bus_b_i : bus_a_i;
            pixel_valid_o <= 1'b1;
        end else begin
            pixel_o       <= '0;
            pixel_valid_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Multiple-slope reset voltage control
    // -------------------------------------------------------------------

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            knee_level_bits_o  <= KNEE_RST;
            knee_gen_connect_o <= 1'b1;
        end else begin
            knee_level_bits_o  <= cfg_r.knee_level_bits;
            knee_gen_connect_o <= ~cfg_r.ext_knee_sel;
        end
    end

endmodule // icr_readout

//--- tb/icr_checker.sv
module icr_checker
    import icr_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              sys_rst_i,
    input wire logic              reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic              int_start_i,
    input wire logic              int_stop_i,
    input wire logic              pix_reset_o,
    input wire logic              pix_sample_o,
    input wire logic              pix_hold_o,
    input wire logic              cal_active_o,
    input wire logic              col_sync_o,
    input wire icr_cols_t         col_sel_o,
    input wire logic [PIX_W-1:0]  bus_a_i,
    input wire logic [PIX_W-1:0]  bus_b_i,
    input wire logic [PIX_W-1:0]  pixel_o,
    input wire logic              pixel_valid_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // One clock domain, so clocking and disable are given once.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_reset_pulse: assert property (
        int_start_i |=> pix_reset_o) else $error("pixel reset pulse missing");
    a_sample_cause: assert property (
        pix_sample_o |-> $past(int_stop_i) && !$past(int_start_i))
        else $error("sample pulse without a stop request");
    a_hold_clear: assert property (
        int_start_i |=> !pix_hold_o) else $error("hold not cleared by start");
    a_sample_hold: assert property (
        pix_sample_o |-> pix_hold_o) else $error("hold low while sampling");
    a_cal_length: assert property (
        $rose(cal_active_o) |-> ##69 cal_active_o ##1
        (!cal_active_o && col_sync_o)) else $error("calibration length wrong");
    a_no_pixel_cal: assert property (
        cal_active_o |-> !pixel_valid_o) else $error("pixel during blanking");
    a_sync_to_stream: assert property (
        col_sync_o |-> ##2 pixel_valid_o) else $error("no shift after sync");
    a_stage_hold: assert property (
        pixel_valid_o && $changed(col_sel_o) |=> $stable(col_sel_o))
        else $error("column stage held less than two clocks");
    a_bus_interleave: assert property (
        $rose(pixel_valid_o) |-> pixel_o == $past(bus_a_i) ##1
        pixel_o == $past(bus_b_i)) else $error("buses not interleaved");
    a_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside its cycle");

endmodule // icr_checker

bind icr_readout icr_checker CHK (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .int_start_i(int_start_i),
    .int_stop_i(int_stop_i), .pix_reset_o(pix_reset_o),
    .pix_sample_o(pix_sample_o), .pix_hold_o(pix_hold_o),
    .cal_active_o(cal_active_o), .col_sync_o(col_sync_o),
    .col_sel_o(col_sel_o), .bus_a_i(bus_a_i), .bus_b_i(bus_b_i),
    .pixel_o(pixel_o), .pixel_valid_o(pixel_valid_o)
);

//--- tb/icr_cam_ctrl.sv
module icr_cam_ctrl (
    input  wire logic sys_clk_i,
    output logic      int_start_o,
    output logic      int_stop_o,
    output logic      row_start_o,
    output logic      row_clock_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Pins rest low between requests, as a real controller leaves them.
    initial begin
        int_start_o = 1'b0;
        int_stop_o  = 1'b0;
        row_start_o = 1'b0;
        row_clock_o = 1'b0;
    end

    task automatic row_request();
        @(posedge sys_clk_i);
        row_start_o <= 1'b1;
        row_clock_o <= 1'b1;
        @(posedge sys_clk_i);
        row_start_o <= 1'b0;
        row_clock_o <= 1'b0;
    endtask

    // One-cycle integration start or stop; returns at the taking edge.
    task automatic shutter(input logic stop);
        @(posedge sys_clk_i);
        int_start_o <= !stop;
        int_stop_o  <= stop;
        @(posedge sys_clk_i);
        int_start_o <= 1'b0;
        int_stop_o  <= 1'b0;
    endtask

endmodule // icr_cam_ctrl

//--- tb/image_core_column_readout_test.sv
module image_core_column_readout_test
    import icr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              sys_clk_i;
    logic              sys_rst_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i;
    logic              reg_wr_i;
    logic              reg_rd_i;
    logic [DATA_W-1:0] reg_rdata_o;
    logic              int_start_i, int_stop_i, row_start_i, row_clock_i;
    logic              pix_reset_o, pix_sample_o, pix_hold_o;
    logic              cal_active_o, col_sync_o, pixel_valid_o;
    icr_cols_t         col_sel_o;
    logic [PIX_W-1:0]  bus_a_i, bus_b_i, pixel_o;
    logic [KNEE_W-1:0] knee_level_bits_o;
    logic              knee_gen_connect_o;
    int                bad_count = 0;
    int                num_checks = 0;

    // Each bus carries the low ten bits of its column number, so any wrong
    // column or order shows up in the stream, except a column exactly 1024 away.
    assign bus_a_i = col_sel_o.even_col[PIX_W-1:0];
    assign bus_b_i = col_sel_o.odd_col[PIX_W-1:0];

    icr_readout DUT (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .int_start_i(int_start_i),
        .int_stop_i(int_stop_i), .row_start_i(row_start_i),
        .row_clock_i(row_clock_i), .pix_reset_o(pix_reset_o),
        .pix_sample_o(pix_sample_o), .pix_hold_o(pix_hold_o),
        .cal_active_o(cal_active_o), .col_sync_o(col_sync_o),
        .col_sel_o(col_sel_o), .bus_a_i(bus_a_i), .bus_b_i(bus_b_i),
        .pixel_o(pixel_o), .pixel_valid_o(pixel_valid_o),
        .knee_level_bits_o(knee_level_bits_o),
        .knee_gen_connect_o(knee_gen_connect_o)
    );

    icr_cam_ctrl CTRL (
        .sys_clk_i(sys_clk_i), .int_start_o(int_start_i),
        .int_stop_o(int_stop_i), .row_start_o(row_start_i),
        .row_clock_o(row_clock_i)
    );

    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask

    // Column expected at stream position k; sub-sampling reads two of
    // every four columns, the swaps choosing which two.
    function automatic logic [9:0] exp_col(input logic [2:0] m,
                                           input int st, input int k);
        int c;
        int o0;
        int o1;
        case (m[2:1])
            2'b00: begin o0 = 0; o1 = 1; end
            2'b01: begin o0 = 0; o1 = 2; end
            2'b10: begin o0 = 1; o1 = 3; end
            default: begin o0 = 2; o1 = 3; end
        endcase
        c = m[0] ? st + 4 * (k / 2) + (k % 2 ? o1 : o0) : st + k;
        return 10'(c);
    endfunction

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_reset_vals();
        reg_check(REG_CTRL, 16'h0000);
        reg_check(REG_START, 16'h0000);
        reg_check(REG_LEN, 16'h027f);
        reg_check(REG_STATUS, 16'h0000);
        reg_check(4'h2, 16'h0000);
        chk({12'h0, knee_gen_connect_o, knee_level_bits_o}, 16'h0008);
    endtask

    task automatic t_knee();
        reg_write(REG_CTRL, 16'h0508);
        reg_write(4'h2, 16'hffff);
        repeat (2) @(posedge sys_clk_i);
        #1 chk({15'h0, knee_gen_connect_o}, 16'h0000);
        chk({13'h0, knee_level_bits_o}, 16'h0005);
        reg_check(REG_CTRL, 16'h0508);
        reg_write(REG_CTRL, 16'h0000);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk({12'h0, knee_gen_connect_o, knee_level_bits_o}, 16'h0008);
    endtask

    task automatic t_shutter();
        CTRL.shutter(1'b0);
        #1 chk({13'h0, pix_reset_o, pix_sample_o, pix_hold_o}, 16'h4);
        CTRL.shutter(1'b1);
        #1 chk({13'h0, pix_reset_o, pix_sample_o, pix_hold_o}, 16'h3);
    endtask

    // One row: blanking length, then every pixel and the exact count.
    task automatic t_row(input logic [2:0] m, input int st, input int len);
        int cnt;
        logic [15:0] want;
        reg_write(REG_CTRL, {13'h0, m});
        reg_write(REG_START, 16'(st));
        reg_write(REG_LEN, 16'(len));
        CTRL.row_request();
        cnt = 0;
        while (pixel_valid_o !== 1'b1 && cnt < 200) begin
            @(posedge sys_clk_i);
            #1 cnt++;
        end
        // Edges from the request: calibration, one sync, one load.
        chk(16'(cnt), 16'(CAL_CYCLES + 2));
        for (int k = 0; k < 2 * (len + 1); k++) begin
            want = {6'h1, exp_col(m, st, k)};
            chk({5'h0, pixel_valid_o, pixel_o}, want);
            @(posedge sys_clk_i);
            #1;
        end
        chk({15'h0, pixel_valid_o}, 16'h0000);
    endtask

    // -------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -------------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        sys_rst_i   = 1'b1;
        reg_addr_i  = '0;
        reg_wdata_i = '0;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_reset_vals();
        t_knee();
        t_shutter();
        t_row(3'b000, 6, 3);
        t_row(3'b001, 8, 3);
        t_row(3'b011, 8, 3);
        t_row(3'b101, 8, 3);
        t_row(3'b111, 636, 3);
        t_row(3'b110, 1272, 3);
        results();
    end

    // The run needs about 560 clocks; about nine times that means a hang.
    initial begin
        #(5000 * 50);
        bad_count++;
        results();
    end

endmodule // image_core_column_readout_test
